//--- inc/mic_pkg.sv
// package for the mcu interrupt controller: register offsets, field layout, vectors
// assumes a 32-bit apb slave with one aligned word per 8-bit register
package mic_pkg;

	// register byte offsets
	localparam logic [7:0] MIC_OFS_EDGE = 8'h00; // pin_edge_select_reg
	localparam logic [7:0] MIC_OFS_CTL0 = 8'h04; // pins 0/1, group 0, global enable
	localparam logic [7:0] MIC_OFS_CTL1 = 8'h08; // group 1, time bases, conversion done
	localparam logic [7:0] MIC_OFS_CTL2 = 8'h0c; // comparators, groups 2/3
	localparam logic [7:0] MIC_OFS_CTL3 = 8'h10; // pins 2/3
	localparam logic [7:0] MIC_OFS_GRP0 = 8'h14; // timer 0 group
	localparam logic [7:0] MIC_OFS_GRP1 = 8'h18; // uart/serial/eeprom/lvd group
	localparam logic [7:0] MIC_OFS_GRP2 = 8'h1c; // timer1_i2c_group_irq
	localparam logic [7:0] MIC_OFS_GRP3 = 8'h20; // timer23_group_irq
	localparam logic [7:0] MIC_OFS_STAT = 8'h24; // read-only controller status

	localparam logic [7:0] MIC_RST_REG = 8'h00;

	// writable bit masks; unimplemented bits read zero
	localparam logic [7:0] MIC_MASK_CTL0 = 8'h7f;
	localparam logic [7:0] MIC_MASK_CTL3 = 8'h33;
	localparam logic [7:0] MIC_MASK_GRP0 = 8'h33;
	localparam logic [7:0] MIC_MASK_GRP2 = 8'hbb;

	// edge select codes
	localparam logic [1:0] MIC_EDGE_OFF = 2'h0;
	localparam logic [1:0] MIC_EDGE_RISE = 2'h1;
	localparam logic [1:0] MIC_EDGE_FALL = 2'h2;
	localparam logic [1:0] MIC_EDGE_BOTH = 2'h3;

	// source index, in priority order (0 highest)
	localparam int MIC_NSRC = 14;
	localparam int MIC_SRC_PIN0 = 0;
	localparam int MIC_SRC_PIN1 = 1;
	localparam int MIC_SRC_GRP0 = 2;
	localparam int MIC_SRC_CONV = 3;
	localparam int MIC_SRC_TB0 = 4;
	localparam int MIC_SRC_TB1 = 5;
	localparam int MIC_SRC_GRP1 = 6;
	localparam int MIC_SRC_GRP2 = 7;
	localparam int MIC_SRC_GRP3 = 8;
	localparam int MIC_SRC_CMP0 = 9;
	localparam int MIC_SRC_CMP1 = 10;
	localparam int MIC_SRC_PIN2 = 11;
	localparam int MIC_SRC_PIN3 = 12;
	localparam int MIC_SRC_NONE = 13;

	// vector base and spacing in program words
	localparam logic [11:0] MIC_VEC_BASE = 12'h004;
	localparam logic [11:0] MIC_VEC_STEP = 12'h004;

	// grant sequencer states
	typedef enum logic [2:0] {
		MIC_ST_IDLE = 3'b001,
		MIC_ST_GRANT = 3'b010,
		MIC_ST_WAIT = 3'b100
	} mic_state_t;

endpackage

//--- hdl/mic_pin_edge.sv
// one external interrupt pin: three-stage synchroniser and edge detector
// assumes the pin is asynchronous to REF_CLK
`timescale 1ns/1ps
module mic_pin_edge
	import mic_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic [1:0] sel,
	output logic hit
);
	logic [2:0] sync_q;
	logic level_q;
	logic moved;

	// stage 0 is only read by stage 1
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], pin};
		end
	end

	// last agreed level; resets low, so a pin idling high shows one rise after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else if (sync_q[1] == sync_q[2]) begin
			level_q <= sync_q[2];
		end
	end

	// a change counts once the second and third stages agree on a new level
	assign moved = (sync_q[1] == sync_q[2]) && (sync_q[2] != level_q);

	always_comb begin
		case (sel)
			MIC_EDGE_RISE: hit = moved & sync_q[2];
			MIC_EDGE_FALL: hit = moved & ~sync_q[2];
			MIC_EDGE_BOTH: hit = moved;
			default: hit = 1'b0; // off code: pin function disabled
		endcase
	end
endmodule

//--- hdl/mic_irq_ctrl.sv
// interrupt controller top: flag/enable registers on apb, edge pins, grant to cpu sequencer
// assumes source events are one-cycle pulses on REF_CLK; the cpu takes a grant in one cycle
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mic_irq_ctrl
	import mic_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0] PIN_IRQ,
	input wire logic [3:0] PIN_IS_INPUT,
	input wire logic [1:0] COMPARATOR_OUTPUT_BIT,
	input wire logic CONV_DONE,
	input wire logic [1:0] TIME_BASE_TICK,
	input wire logic [1:0] TMR0_MATCH,
	input wire logic [1:0] TMR1_MATCH,
	input wire logic [1:0] TMR2_MATCH,
	input wire logic [1:0] TMR3_MATCH,
	input wire logic [3:0] GRP1_EVENT,
	input wire logic TWOWIRE_TIMEOUT,
	input wire logic STACK_FULL,
	input wire logic [11:0] NEXT_PC,
	output logic IRQ_REQ,
	output logic [11:0] IRQ_VECTOR,
	output logic [11:0] IRQ_PUSH_PC,
	output logic IRQ_PUSH,
	output logic WAKE
);
	logic [7:0] edge_q;
	logic [7:0] ctl0_q, ctl1_q, ctl2_q, ctl3_q;
	logic [7:0] grp0_q, grp1_q, grp2_q, grp3_q;
	logic [1:0] cmp_q;
	logic [3:0] pin_hit;
	logic [MIC_NSRC-2:0] pend, enab, req;
	logic [3:0] grp_member;
	logic [12:0] mem_q;
	logic global_irq_enable;
	logic wr_en, rd_en, addr_ok;
	logic [31:0] rdata_d;
	logic [3:0] grant_idx_q;
	logic [11:0] vec_q, push_q;
	logic take;
	mic_state_t state_q;

	// pick the highest-priority requesting source
	function automatic logic [3:0] mic_pick(input logic [MIC_NSRC-2:0] r);
		logic [3:0] idx;
		idx = 4'(MIC_SRC_NONE);
		for (int i = MIC_NSRC - 2; i >= 0; i--) begin
			if (r[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// apb write of one masked byte
	function automatic logic [7:0] mic_wbyte(input logic [7:0] d, input logic [7:0] m);
		return d & m;
	endfunction

	assign wr_en = PSEL & PENABLE & PWRITE;
	assign rd_en = PSEL & PENABLE & ~PWRITE;
	assign PREADY = 1'b1; // zero wait states
	assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR <= MIC_OFS_STAT);
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;
	assign global_irq_enable = ctl0_q[0];

	// pin edge detectors; port direction gates the pin
	for (genvar p = 0; p < 4; p++) begin : g_pin
		logic raw_hit;
		mic_pin_edge u_edge (
			.clk(REF_CLK),
			.rst_n(RESETN),
			.pin(PIN_IRQ[p]),
			.sel(edge_q[2*p +: 2]),
			.hit(raw_hit)
		);
		assign pin_hit[p] = raw_hit & PIN_IS_INPUT[p];
	end

	// comparator output history for change detection
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			cmp_q <= 2'h0;
		end else begin
			cmp_q <= COMPARATOR_OUTPUT_BIT;
		end
	end

	// any member flag newly set; per bit, so a second member still raises the group
	always_comb begin
		grp_member[0] = |(grp0_q[5:4] & ~mem_q[12:11]);
		grp_member[1] = |(grp1_q[7:4] & ~mem_q[10:7]);
		grp_member[2] = |({grp2_q[7], grp2_q[5:4]} & ~mem_q[6:4]);
		grp_member[3] = |(grp3_q[7:4] & ~mem_q[3:0]);
	end

	// member flag history for the per-bit rise detection
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			mem_q <= 13'h0;
		end else begin
			mem_q <= {grp0_q[5:4], grp1_q[7:4], grp2_q[7], grp2_q[5:4], grp3_q[7:4]};
		end
	end

	// pending and enable vectors in priority order
	always_comb begin
		pend = '0;
		enab = '0;
		pend[MIC_SRC_PIN0] = ctl0_q[4];
		enab[MIC_SRC_PIN0] = ctl0_q[1];
		pend[MIC_SRC_PIN1] = ctl0_q[5];
		enab[MIC_SRC_PIN1] = ctl0_q[2];
		pend[MIC_SRC_GRP0] = ctl0_q[6];
		enab[MIC_SRC_GRP0] = ctl0_q[3];
		pend[MIC_SRC_CONV] = ctl1_q[4];
		enab[MIC_SRC_CONV] = ctl1_q[0];
		pend[MIC_SRC_TB0] = ctl1_q[5];
		enab[MIC_SRC_TB0] = ctl1_q[1];
		pend[MIC_SRC_TB1] = ctl1_q[6];
		enab[MIC_SRC_TB1] = ctl1_q[2];
		pend[MIC_SRC_GRP1] = ctl1_q[7];
		enab[MIC_SRC_GRP1] = ctl1_q[3];
		pend[MIC_SRC_GRP2] = ctl2_q[4];
		enab[MIC_SRC_GRP2] = ctl2_q[0];
		pend[MIC_SRC_GRP3] = ctl2_q[5];
		enab[MIC_SRC_GRP3] = ctl2_q[1];
		pend[MIC_SRC_CMP0] = ctl2_q[6];
		enab[MIC_SRC_CMP0] = ctl2_q[2];
		pend[MIC_SRC_CMP1] = ctl2_q[7];
		enab[MIC_SRC_CMP1] = ctl2_q[3];
		pend[MIC_SRC_PIN2] = ctl3_q[4];
		enab[MIC_SRC_PIN2] = ctl3_q[0];
		pend[MIC_SRC_PIN3] = ctl3_q[5];
		enab[MIC_SRC_PIN3] = ctl3_q[1];
	end

	// a flag only requests when its enable is set
	assign req = pend & enab;
	// global enable and stack state gate acceptance
	assign take = (state_q == MIC_ST_IDLE) & global_irq_enable & ~STACK_FULL & (|req);
	// any set flag wakes the core, enabled or not
	assign WAKE = |pend;

	// grant sequencer: one cycle request, then wait for idle
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			state_q <= MIC_ST_IDLE;
			grant_idx_q <= 4'(MIC_SRC_NONE);
			vec_q <= 12'h000;
			push_q <= 12'h000;
		end else begin
			case (state_q)
				MIC_ST_IDLE: begin
					if (take) begin
						state_q <= MIC_ST_GRANT;
						grant_idx_q <= mic_pick(req);
						// own vector per source, groups each own shared vector
						vec_q <= MIC_VEC_BASE + MIC_VEC_STEP * 12'(mic_pick(req));
						push_q <= NEXT_PC;
					end
				end
				MIC_ST_GRANT: state_q <= MIC_ST_WAIT;
				MIC_ST_WAIT: state_q <= MIC_ST_IDLE;
				default: state_q <= MIC_ST_IDLE;
			endcase
		end
	end

	// grant outputs: push pc and load vector in the same cycle
	assign IRQ_REQ = (state_q == MIC_ST_GRANT);
	assign IRQ_PUSH = (state_q == MIC_ST_GRANT);
	assign IRQ_VECTOR = vec_q;
	assign IRQ_PUSH_PC = push_q;

	// edge select register
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			edge_q <= MIC_RST_REG;
		end else if (wr_en && PADDR == MIC_OFS_EDGE) begin
			edge_q <= PWDATA[7:0];
		end
	end

	// control 0: pins 0/1, group 0, global enable; hardware set beats clear
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ctl0_q <= MIC_RST_REG;
		end else begin
			logic [7:0] v;
			v = ctl0_q;
			if (wr_en && PADDR == MIC_OFS_CTL0) begin
				v = mic_wbyte(PWDATA[7:0], MIC_MASK_CTL0);
			end
			if (IRQ_REQ) begin
				v[0] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_PIN0)) v[4] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_PIN1)) v[5] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_GRP0)) v[6] = 1'b0;
			end
			// flags set even while blocked; pin flags only while their own enable is set
			if (pin_hit[0] && ctl0_q[1]) v[4] = 1'b1;
			if (pin_hit[1] && ctl0_q[2]) v[5] = 1'b1;
			if (grp_member[0]) v[6] = 1'b1;
			ctl0_q <= v;
		end
	end

	// control 1: group 1, time bases, conversion done
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ctl1_q <= MIC_RST_REG;
		end else begin
			logic [7:0] v;
			v = ctl1_q;
			if (wr_en && PADDR == MIC_OFS_CTL1) v = PWDATA[7:0];
			if (IRQ_REQ) begin
				if (grant_idx_q == 4'(MIC_SRC_CONV)) v[4] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_TB0)) v[5] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_TB1)) v[6] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_GRP1)) v[7] = 1'b0;
			end
			if (CONV_DONE) v[4] = 1'b1;
			if (TIME_BASE_TICK[0]) v[5] = 1'b1;
			if (TIME_BASE_TICK[1]) v[6] = 1'b1;
			if (grp_member[1]) v[7] = 1'b1;
			ctl1_q <= v;
		end
	end

	// control 2: comparators and groups 2/3
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ctl2_q <= MIC_RST_REG;
		end else begin
			logic [7:0] v;
			v = ctl2_q;
			if (wr_en && PADDR == MIC_OFS_CTL2) v = PWDATA[7:0];
			if (IRQ_REQ) begin
				if (grant_idx_q == 4'(MIC_SRC_GRP2)) v[4] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_GRP3)) v[5] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_CMP0)) v[6] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_CMP1)) v[7] = 1'b0;
			end
			if (grp_member[2]) v[4] = 1'b1;
			if (grp_member[3]) v[5] = 1'b1;
			if (COMPARATOR_OUTPUT_BIT[0] != cmp_q[0]) v[6] = 1'b1;
			if (COMPARATOR_OUTPUT_BIT[1] != cmp_q[1]) v[7] = 1'b1;
			ctl2_q <= v;
		end
	end

	// control 3: pins 2/3
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ctl3_q <= MIC_RST_REG;
		end else begin
			logic [7:0] v;
			v = ctl3_q;
			if (wr_en && PADDR == MIC_OFS_CTL3) v = mic_wbyte(PWDATA[7:0], MIC_MASK_CTL3);
			if (IRQ_REQ) begin
				if (grant_idx_q == 4'(MIC_SRC_PIN2)) v[4] = 1'b0;
				if (grant_idx_q == 4'(MIC_SRC_PIN3)) v[5] = 1'b0;
			end
			if (pin_hit[2] && ctl3_q[0]) v[4] = 1'b1;
			if (pin_hit[3] && ctl3_q[1]) v[5] = 1'b1;
			ctl3_q <= v;
		end
	end

	// group member registers: only software clears members
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			grp0_q <= MIC_RST_REG;
			grp1_q <= MIC_RST_REG;
			grp2_q <= MIC_RST_REG;
			grp3_q <= MIC_RST_REG;
		end else begin
			logic [7:0] v0, v1, v2, v3;
			v0 = grp0_q;
			v1 = grp1_q;
			v2 = grp2_q;
			v3 = grp3_q;
			if (wr_en && PADDR == MIC_OFS_GRP0) v0 = mic_wbyte(PWDATA[7:0], MIC_MASK_GRP0);
			if (wr_en && PADDR == MIC_OFS_GRP1) v1 = PWDATA[7:0];
			if (wr_en && PADDR == MIC_OFS_GRP2) v2 = mic_wbyte(PWDATA[7:0], MIC_MASK_GRP2);
			if (wr_en && PADDR == MIC_OFS_GRP3) v3 = PWDATA[7:0];
			// member flags: a/p flag pairs sit four bits above their enables
			v0[5:4] = v0[5:4] | TMR0_MATCH;
			v1[7:4] = v1[7:4] | GRP1_EVENT;
			v2[5] = v2[5] | TMR1_MATCH[1];
			v2[4] = v2[4] | TMR1_MATCH[0];
			v2[7] = v2[7] | TWOWIRE_TIMEOUT;
			v3[7:6] = v3[7:6] | TMR3_MATCH;
			v3[5:4] = v3[5:4] | TMR2_MATCH;
			grp0_q <= v0;
			grp1_q <= v1;
			grp2_q <= v2;
			grp3_q <= v3;
		end
	end

	// apb read mux; reserved bits read zero
	always_comb begin
		rdata_d = 32'h0;
		case (PADDR)
			MIC_OFS_EDGE: rdata_d[7:0] = edge_q;
			MIC_OFS_CTL0: rdata_d[7:0] = ctl0_q;
			MIC_OFS_CTL1: rdata_d[7:0] = ctl1_q;
			MIC_OFS_CTL2: rdata_d[7:0] = ctl2_q;
			MIC_OFS_CTL3: rdata_d[7:0] = ctl3_q;
			MIC_OFS_GRP0: rdata_d[7:0] = grp0_q;
			MIC_OFS_GRP1: rdata_d[7:0] = grp1_q;
			MIC_OFS_GRP2: rdata_d[7:0] = grp2_q; // bit 2 reads 0
			MIC_OFS_GRP3: rdata_d[7:0] = grp3_q;
			MIC_OFS_STAT: rdata_d[7:0] = {state_q == MIC_ST_IDLE ? 1'b0 : 1'b1, 3'h0, grant_idx_q};
			default: rdata_d = 32'h0;
		endcase
	end

	// read data registered only while a read is in the setup phase
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			PRDATA <= 32'h0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rdata_d;
		end
	end
endmodule

//--- verif/mic_irq_props.sv
// concurrent checks on the interrupt controller top ports
// assumes a bind into mic_irq_ctrl from the testbench top file
`timescale 1ns/1ps
module mic_irq_props
	import mic_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PSLVERR,
	input wire logic CONV_DONE,
	input wire logic STACK_FULL,
	input wire logic [11:0] NEXT_PC,
	input wire logic IRQ_REQ,
	input wire logic [11:0] IRQ_VECTOR,
	input wire logic [11:0] IRQ_PUSH_PC,
	input wire logic IRQ_PUSH,
	input wire logic WAKE
);
	// one domain, so one clock and one disable for every check
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);

	AST_STACK_BLOCK: assert property (IRQ_REQ |-> !$past(STACK_FULL))
		else $error("grant taken while stack full");
	AST_PUSH_PAIR: assert property (IRQ_PUSH == IRQ_REQ)
		else $error("push and grant differ");
	AST_PUSH_PC: assert property (IRQ_REQ |-> IRQ_PUSH_PC == $past(NEXT_PC))
		else $error("pushed pc is not the next pc");
	AST_NO_NEST: assert property (IRQ_REQ |=> !IRQ_REQ [*2])
		else $error("grant nested too soon");
	AST_VEC_SET: assert property (IRQ_REQ |-> IRQ_VECTOR[1:0] == 2'h0 && IRQ_VECTOR >= MIC_VEC_BASE
		&& IRQ_VECTOR <= 12'h034)
		else $error("vector outside the table");
	AST_NEED_FLAG: assert property (IRQ_REQ |-> $past(WAKE))
		else $error("grant with no pending flag");
	AST_CONV_WAKE: assert property (CONV_DONE |=> WAKE)
		else $error("conversion done did not wake");
	AST_FLAG_KEPT: assert property (WAKE && !IRQ_REQ && !PSEL |=> WAKE)
		else $error("pending flag lost");

	// main scenarios reached
	cover property (IRQ_REQ && IRQ_VECTOR == 12'h004);
	cover property (STACK_FULL && WAKE);
	cover property (PSEL && PENABLE && PSLVERR);
endmodule

//--- verif/mic_cpu_model.sv
// cpu sequencer stand-in: program counter and return stack
// assumes one push per grant pulse and one-cycle pop requests
`timescale 1ns/1ps
module mic_cpu_model #(
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [11:0] push_pc,
	input wire logic [11:0] vector,
	input wire logic pop,
	output logic stack_full,
	output logic [11:0] next_pc
);
	logic [11:0] stack_q [$];

	// pc walks each cycle; a grant jumps, a return pops
	always @(posedge clk) begin
		if (!rst_n) begin
			stack_q.delete();
			next_pc <= 12'h100;
		end else if (push) begin
			stack_q.push_back(push_pc);
			next_pc <= vector;
		end else if (pop && stack_q.size() > 0) begin
			next_pc <= stack_q.pop_back();
		end else begin
			next_pc <= next_pc + 12'h001;
		end
		stack_full <= rst_n && (stack_q.size() >= DEPTH);
	end
endmodule

//--- verif/tb.sv
// self-checking bench for the interrupt controller
// assumes mic_pkg, the cpu stand-in and the checker are compiled first
`timescale 1ns/1ps
module tb;
	import mic_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_done = 1'b0, ret = 1'b0, slv;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, d;
	logic [3:0] pin_irq = 4'h0, pin_in = 4'hf;
	logic [1:0] cmp_out = 2'h0, tb_tick = 2'h0, tmr2 = 2'h0, tmr1 = 2'h0;
	logic pready, pslverr, stack_full, irq_req, irq_push, wake;
	logic [11:0] next_pc, irq_vector, irq_push_pc;
	logic [31:0] exp_vec [$];
	int fail_count = 0, n_checks = 0, cyc = 0;

	initial forever #12.5 clk = ~clk;

	mic_irq_ctrl i_mic_irq_ctrl(.REF_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PIN_IRQ(pin_irq), .PIN_IS_INPUT(pin_in),
		.COMPARATOR_OUTPUT_BIT(cmp_out), .CONV_DONE(conv_done), .TIME_BASE_TICK(tb_tick),
		.TMR0_MATCH(2'h0), .TMR1_MATCH(tmr1), .TMR2_MATCH(tmr2), .TMR3_MATCH(2'h0),
		.GRP1_EVENT(4'h0), .TWOWIRE_TIMEOUT(1'b0), .STACK_FULL(stack_full), .NEXT_PC(next_pc),
		.IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_PUSH_PC(irq_push_pc),
		.IRQ_PUSH(irq_push), .WAKE(wake));
	mic_cpu_model #(.DEPTH(4)) i_cpu(.clk(clk), .rst_n(rst_n), .push(irq_push),
		.push_pc(irq_push_pc), .vector(irq_vector), .pop(ret), .stack_full(stack_full),
		.next_pc(next_pc));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// every grant must match the oldest expected vector; unexpected ones fail
	always @(posedge clk) begin
		cyc++;
		if (rst_n && irq_req === 1'b1) begin
			if (exp_vec.size() == 0) chk({20'h0, irq_vector}, 32'hffffffff);
			else chk({20'h0, irq_vector}, exp_vec.pop_front());
		end
		if (cyc == 5000) begin
			fail_count++;
			end_sim();
		end
	end

	// apb master: request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// only the bench timeout ends this wait
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	function automatic logic [31:0] vec(input int s);
		return 32'(MIC_VEC_BASE) + 32'(MIC_VEC_STEP) * 32'(s);
	endfunction

	// bounded wait for all expected grants
	task automatic wait_g();
		for (int n = 0; n < 20 && exp_vec.size() > 0; n++) @(posedge clk);
		chk(32'(exp_vec.size()), 32'h0);
	endtask

	task automatic go(input int s, input logic [31:0] c0);
		exp_vec.push_back(vec(s));
		wr(MIC_OFS_CTL0, c0);
		wait_g();
	endtask

	// pin synchroniser needs a few edges before the flag shows
	task automatic pin(input logic v);
		pin_irq[0] <= v;
		repeat (6) @(posedge clk);
	endtask

	task automatic pop();
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		@(posedge clk);
	endtask

	initial begin
		void'($urandom(66));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// status shows the no-grant index after reset
		for (int a = 0; a <= 36; a += 4) rdc(8'(a), a == 36 ? 32'(MIC_SRC_NONE) : 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, slv}, 32'h1);
		chk(rd, 32'h0);
		// random field patterns, global enable kept off
		for (int i = 0; i < 4; i++) begin
			d = {24'h0, 8'($urandom())};
			wr(MIC_OFS_GRP2, d);
			rdc(MIC_OFS_GRP2, d & 32'(MIC_MASK_GRP2));
			wr(MIC_OFS_GRP3, d);
			rdc(MIC_OFS_GRP3, d);
			wr(MIC_OFS_EDGE, d);
			rdc(MIC_OFS_EDGE, d);
		end
		for (int a = 0; a <= 32; a += 4) wr(8'(a), 32'h0);
		// timer 1 members: a second member rising raises the group flag again
		tmr1 <= 2'h1;
		@(posedge clk);
		tmr1 <= 2'h0;
		repeat (3) @(posedge clk);
		rdc(MIC_OFS_GRP2, 32'h10);
		wr(MIC_OFS_CTL2, 32'h0);
		tmr1 <= 2'h2;
		@(posedge clk);
		tmr1 <= 2'h0;
		repeat (3) @(posedge clk);
		rdc(MIC_OFS_CTL2, 32'h10);
		rdc(MIC_OFS_GRP2, 32'h30);
		wr(MIC_OFS_GRP2, 32'h0);
		wr(MIC_OFS_CTL2, 32'h0);
		// events land with every enable off
		conv_done <= 1'b1;
		tb_tick <= 2'h2;
		@(posedge clk);
		conv_done <= 1'b0;
		tb_tick <= 2'h0;
		@(posedge clk);
		chk({31'h0, wake}, 32'h1);
		rdc(MIC_OFS_CTL1, 32'h50);
		wr(MIC_OFS_CTL1, 32'h11);
		repeat (6) @(posedge clk);
		go(MIC_SRC_CONV, 32'h1);
		rdc(MIC_OFS_CTL0, 32'h0);
		rdc(MIC_OFS_CTL1, 32'h1);
		wr(MIC_OFS_CTL1, 32'h33);
		go(MIC_SRC_CONV, 32'h1);
		go(MIC_SRC_TB0, 32'h1);
		rdc(MIC_OFS_CTL1, 32'h3);
		chk({31'h0, wake}, 32'h0);
		// software presets a flag before sleep; it shows on the wake line
		wr(MIC_OFS_CTL1, 32'h20);
		chk({31'h0, wake}, 32'h1);
		wr(MIC_OFS_CTL0, 32'h1);
		repeat (6) @(posedge clk);
		rdc(MIC_OFS_CTL0, 32'h1);
		wr(MIC_OFS_CTL0, 32'h0);
		wr(MIC_OFS_CTL1, 32'h0);
		// each edge code against a rise then a fall
		for (int c = 0; c < 4; c++) begin
			wr(MIC_OFS_EDGE, 32'(c));
			wr(MIC_OFS_CTL0, 32'h2);
			pin(1'b1);
			rdc(MIC_OFS_CTL0, c[0] ? 32'h12 : 32'h2);
			wr(MIC_OFS_CTL0, 32'h2);
			pin(1'b0);
			rdc(MIC_OFS_CTL0, c[1] ? 32'h12 : 32'h2);
		end
		go(MIC_SRC_PIN0, 32'h13);
		rdc(MIC_OFS_CTL0, 32'h2);
		pin_in <= 4'h0;
		pin(1'b1);
		rdc(MIC_OFS_CTL0, 32'h2);
		pin_in <= 4'hf;
		// stack is full now: comparator request must wait for a pop
		cmp_out <= 2'h1;
		repeat (4) @(posedge clk);
		rdc(MIC_OFS_CTL2, 32'h40);
		wr(MIC_OFS_CTL2, 32'h44);
		exp_vec.push_back(vec(MIC_SRC_CMP0));
		wr(MIC_OFS_CTL0, 32'h1);
		repeat (8) @(posedge clk);
		chk(32'(exp_vec.size()), 32'h1);
		pop();
		wait_g();
		rdc(MIC_OFS_CTL2, 32'h4);
		cmp_out <= 2'h0;
		repeat (4) @(posedge clk);
		rdc(MIC_OFS_CTL2, 32'h44);
		// grouped timer 2 match
		pop();
		wr(MIC_OFS_CTL2, 32'h2);
		wr(MIC_OFS_GRP3, 32'h2);
		tmr2 <= 2'h2;
		@(posedge clk);
		tmr2 <= 2'h0;
		repeat (3) @(posedge clk);
		rdc(MIC_OFS_CTL2, 32'h22);
		go(MIC_SRC_GRP3, 32'h1);
		rdc(MIC_OFS_CTL2, 32'h2);
		rdc(MIC_OFS_GRP3, 32'h22);
		end_sim();
	end
endmodule

bind mic_irq_ctrl mic_irq_props i_mic_irq_props(.REF_CLK(REF_CLK), .RESETN(RESETN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PSLVERR(PSLVERR), .CONV_DONE(CONV_DONE),
	.STACK_FULL(STACK_FULL), .NEXT_PC(NEXT_PC), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
	.IRQ_PUSH_PC(IRQ_PUSH_PC), .IRQ_PUSH(IRQ_PUSH), .WAKE(WAKE));
